// >>> rtl/data_pointer_unit.sv
/*
 * Data pointer unit: the 16-bit data pointer, indexed constant reads,
 * indexed and short absolute jumps, return address pops, stack pushes
 * and external data reads.
 * Assumes a decoder on the same clock that issues one command at a time
 * while cmd_ready is high, and memories on the same clock that answer a
 * read with mem_ack; stack RAM answers one cycle after stack_rd.
 */
`timescale 1ns/100ps
`include "pointer_unit_regs.svh"

module data_pointer_unit (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       cmd_valid,
	input  wire pointer_unit_pkg::op_t      cmd_op,
	input  wire logic [7:0]                 cmd_data,
	output logic                            cmd_ready,
	input  wire logic                       byte_valid,
	input  wire logic [7:0]                 byte_data,
	input  wire logic [7:0]                 acc_in,
	input  wire logic [15:0]                pc_in,
	input  wire logic [7:0]                 index_in,
	input  wire logic [7:0]                 sp_in,
	output logic [7:0]                      pointer_high_byte,
	output logic [7:0]                      pointer_low_byte,
	output logic                            mem_req,
	output pointer_unit_pkg::space_t        mem_space,
	output logic [15:0]                     mem_addr,
	input  wire logic                       mem_ack,
	input  wire logic [7:0]                 mem_rdata,
	output logic [7:0]                      acc_out,
	output logic                            acc_we,
	output logic [15:0]                     pc_out,
	output logic                            pc_we,
	output logic                            stack_rd,
	output logic                            stack_wr,
	output logic [7:0]                      stack_addr,
	output logic [7:0]                      stack_wdata,
	input  wire logic [7:0]                 stack_rdata,
	output logic [7:0]                      sp_out,
	output logic                            sp_we,
	output logic                            flag_we
);

	// ======================================================================
	// State
	pointer_unit_pkg::state_t state;
	pointer_unit_pkg::state_t next_state;
	logic [15:0]                ptr;
	logic [2:0]                 page;
	logic [7:0]                 sp_cur;
	logic [7:0]                 pop_high;

	// ======================================================================
	// Command decode
	wire take        = (state == pointer_unit_pkg::ST_IDLE) && cmd_valid;
	wire take_load   = take && (cmd_op == pointer_unit_pkg::OP_LOAD_IMM);
	wire take_inc    = take && (cmd_op == pointer_unit_pkg::OP_INC);
	wire take_mc_ptr = take && (cmd_op == pointer_unit_pkg::OP_CONST_PTR);
	wire take_mc_pc  = take && (cmd_op == pointer_unit_pkg::OP_CONST_PC);
	wire take_jmp    = take && (cmd_op == pointer_unit_pkg::OP_JMP_IDX);
	wire take_short  = take && (cmd_op == pointer_unit_pkg::OP_SHORT_JMP);
	wire take_wr_hi  = take && (cmd_op == pointer_unit_pkg::OP_WR_HIGH);
	wire take_wr_lo  = take && (cmd_op == pointer_unit_pkg::OP_WR_LOW);
	wire take_pop    = take && (cmd_op == pointer_unit_pkg::OP_RETURN);
	wire take_mx_idx = take && (cmd_op == pointer_unit_pkg::OP_EXT_IDX);
	wire take_mx_ptr = take && (cmd_op == pointer_unit_pkg::OP_EXT_PTR);
	wire take_push   = take && (cmd_op == pointer_unit_pkg::OP_PUSH);
	wire take_mem    = take_mc_ptr | take_mc_pc | take_mx_idx | take_mx_ptr;

	// Byte arrivals and completions in the waiting states
	wire imm_hi   = (state == pointer_unit_pkg::ST_IMM_HIGH) && byte_valid;
	wire imm_lo   = (state == pointer_unit_pkg::ST_IMM_LOW) && byte_valid;
	wire jump_lo  = (state == pointer_unit_pkg::ST_JUMP_LOW) && byte_valid;
	wire mem_done = (state == pointer_unit_pkg::ST_MEM_WAIT) && mem_ack;
	// Stack data stands one cycle after each read strobe, hence three steps
	wire pop_hi   = (state == pointer_unit_pkg::ST_POP_HIGH);
	wire pop_lo   = (state == pointer_unit_pkg::ST_POP_LOW);
	wire pop_last = (state == pointer_unit_pkg::ST_POP_LAST);

	// ======================================================================
	// Address arithmetic
	// Full 16-bit sums: carry runs into the high byte and wraps at the top
	wire [15:0] ptr_sum = ptr + {8'h00, acc_in};
	wire [15:0] pc_sum  = pc_in + {8'h00, acc_in};
	wire [15:0] ptr_inc = ptr + 16'h0001;
	// Page bits of the counter are kept, bits 10:8 come from the command and the low byte from the next byte
	wire [15:0] page_target = {pc_in[`PAGE_MSB:`PAGE_LSB], page, byte_data};

	// Pointer update; loads arrive high byte first
	wire [15:0] next_ptr =
		take_inc   ? ptr_inc :
		imm_hi     ? {byte_data, ptr[7:0]} :
		imm_lo     ? {ptr[15:8], byte_data} :
		take_wr_hi ? {cmd_data, ptr[7:0]} :
		take_wr_lo ? {ptr[15:8], cmd_data} :
		ptr;

	// Memory read address; the index register reaches only 256 bytes
	wire [15:0] next_mem_addr =
		take_mc_ptr ? ptr_sum :
		take_mc_pc  ? pc_sum :
		take_mx_idx ? {8'h00, index_in} :
		ptr;
	wire next_space_x = take_mx_idx | take_mx_ptr;

	// Program counter writes from the three jump sources
	wire [15:0] next_pc =
		take_jmp ? ptr_sum :
		jump_lo  ? page_target :
		{pop_high, stack_rdata};
	wire next_pc_we = take_jmp | jump_lo | pop_last;

	// Stack port: pop reads at the pointer, push writes one above it
	wire [7:0] next_stack_addr =
		take_push ? sp_in + `SP_STEP :
		pop_hi    ? sp_cur - `SP_STEP :
		sp_in;
	wire [7:0] next_sp =
		take_push ? sp_in + `SP_STEP :
		sp_cur - `SP_POP_STEP;

	// ======================================================================
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			pointer_unit_pkg::ST_IDLE: begin
				if (take_load)
					next_state = pointer_unit_pkg::ST_IMM_HIGH;
				else if (take_short)
					next_state = pointer_unit_pkg::ST_JUMP_LOW;
				else if (take_mem)
					next_state = pointer_unit_pkg::ST_MEM_WAIT;
				else if (take_pop)
					next_state = pointer_unit_pkg::ST_POP_HIGH;
			end
			pointer_unit_pkg::ST_IMM_HIGH: begin
				if (byte_valid)
					next_state = pointer_unit_pkg::ST_IMM_LOW;
			end
			pointer_unit_pkg::ST_IMM_LOW,
			pointer_unit_pkg::ST_JUMP_LOW: begin
				if (byte_valid)
					next_state = pointer_unit_pkg::ST_IDLE;
			end
			pointer_unit_pkg::ST_MEM_WAIT: begin
				if (mem_ack)
					next_state = pointer_unit_pkg::ST_IDLE;
			end
			pointer_unit_pkg::ST_POP_HIGH: begin
				next_state = pointer_unit_pkg::ST_POP_LOW;
			end
			pointer_unit_pkg::ST_POP_LOW: begin
				next_state = pointer_unit_pkg::ST_POP_LAST;
			end
			default: begin
				next_state = pointer_unit_pkg::ST_IDLE;
			end
		endcase
	end

	// State, pointer and captured operands
	always_ff @(posedge clk) begin
		if (rst) begin
			state    <= pointer_unit_pkg::ST_IDLE;
			ptr      <= `PTR_RESET;
			page     <= `PAGE_RESET;
			sp_cur   <= `SP_RESET;
			pop_high <= `BYTE_RESET;
		end else begin
			state    <= next_state;
			ptr      <= next_ptr;
			page     <= take_short ? cmd_data[2:0] : page;
			sp_cur   <= take ? sp_in : sp_cur;
			pop_high <= pop_lo ? stack_rdata : pop_high;
		end
	end

	// Visible pointer bytes and readiness, straight from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			pointer_high_byte <= `BYTE_RESET;
			pointer_low_byte  <= `BYTE_RESET;
			cmd_ready         <= 1'b0;
		end else begin
			pointer_high_byte <= next_ptr[15:8];
			pointer_low_byte  <= next_ptr[7:0];
			cmd_ready         <= (next_state == pointer_unit_pkg::ST_IDLE);
		end
	end

	// Memory read port; address is held until the answer comes
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_req   <= 1'b0;
			mem_space <= pointer_unit_pkg::SPACE_CODE;
			mem_addr  <= `PTR_RESET;
			acc_out   <= `BYTE_RESET;
			acc_we    <= 1'b0;
		end else begin
			mem_req   <= take_mem;
			mem_space <= take_mem ? pointer_unit_pkg::space_t'(next_space_x)
			                      : mem_space;
			mem_addr  <= take_mem ? next_mem_addr : mem_addr;
			acc_out   <= mem_done ? mem_rdata : acc_out;
			acc_we    <= mem_done;
		end
	end

	// Counter and stack ports; flags are never written by this unit
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_out      <= `PC_RESET;
			pc_we       <= 1'b0;
			stack_rd    <= 1'b0;
			stack_wr    <= 1'b0;
			stack_addr  <= `SP_RESET;
			stack_wdata <= `BYTE_RESET;
			sp_out      <= `SP_RESET;
			sp_we       <= 1'b0;
			flag_we     <= 1'b0;
		end else begin
			pc_out      <= next_pc_we ? next_pc : pc_out;
			pc_we       <= next_pc_we;
			stack_rd    <= take_pop | pop_hi;
			stack_wr    <= take_push;
			stack_addr  <= next_stack_addr;
			stack_wdata <= take_push ? cmd_data : stack_wdata;
			sp_out      <= (take_push | pop_last) ? next_sp : sp_out;
			sp_we       <= take_push | pop_last;
			flag_we     <= 1'b0;
		end
	end

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	imm_high_first_a: assert property (
		imm_hi ##1 imm_lo |=> pointer_high_byte == $past(byte_data, 2)
		&& pointer_low_byte == $past(byte_data))
		else $error("immediate load bytes out of order");

	inc_carry_a: assert property (
		take_inc |=> {pointer_high_byte, pointer_low_byte}
		== $past(ptr) + 16'h0001)
		else $error("pointer increment wrong");

	no_flags_a: assert property (
		!flag_we)
		else $error("status flags written");

	const_ptr_addr_a: assert property (
		take_mc_ptr |=> mem_req && mem_addr == $past(ptr) + {8'h00,
		$past(acc_in)} && mem_space == pointer_unit_pkg::SPACE_CODE)
		else $error("indexed read address wrong");

	read_keeps_ptr_a: assert property (
		(take_mem || state == pointer_unit_pkg::ST_MEM_WAIT)
		|=> $stable(ptr))
		else $error("pointer changed during read");

	const_pc_addr_a: assert property (
		take_mc_pc |=> mem_addr == $past(pc_in) + {8'h00, $past(acc_in)})
		else $error("counter relative address wrong");

	read_to_acc_a: assert property (
		mem_done |=> acc_we && acc_out == $past(mem_rdata))
		else $error("read byte not delivered");

	jmp_target_a: assert property (
		take_jmp |=> pc_we && !acc_we && $stable(ptr)
		&& pc_out == $past(ptr) + {8'h00, $past(acc_in)})
		else $error("indexed jump wrong");

	short_jump_page_a: assert property (
		jump_lo |=> pc_we && pc_out[15:11] == $past(pc_in[15:11])
		&& pc_out[7:0] == $past(byte_data))
		else $error("short jump left its page");

	return_pop_a: assert property (
		take_pop |-> ##4 pc_we && sp_we
		&& sp_out == $past(sp_in, 4) - 8'h02)
		else $error("return pop wrong");

	push_pre_inc_a: assert property (
		take_push |=> stack_wr && stack_addr == $past(sp_in) + 8'h01
		&& sp_out == stack_addr)
		else $error("push address wrong");

	ext_idx_addr_a: assert property (
		take_mx_idx |=> mem_space == pointer_unit_pkg::SPACE_XDATA
		&& mem_addr == {8'h00, $past(index_in)})
		else $error("indexed external address wrong");

	ext_ptr_addr_a: assert property (
		take_mx_ptr |=> mem_addr == $past(ptr))
		else $error("pointer external address wrong");

	load_seen_c: cover property (imm_hi ##1 imm_lo);
	jump_seen_c: cover property (take_jmp ##1 pc_we);
	return_seen_c: cover property (take_pop ##4 pc_we);
	wrap_seen_c: cover property (take_mc_ptr && ptr_sum < ptr);

endmodule : data_pointer_unit

// >>> rtl/pointer_unit_pkg.sv
/*
 * Types of the data pointer and table look-up unit: command codes,
 * sequencer states and memory space selection.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pointer_unit_pkg;

	// ======================================================================
	// Commands issued by the instruction decoder
	typedef enum logic [3:0] {
		OP_NOP          = 4'h0,
		OP_LOAD_IMM     = 4'h1,
		OP_INC          = 4'h2,
		OP_CONST_PTR    = 4'h3,
		OP_CONST_PC     = 4'h4,
		OP_JMP_IDX      = 4'h5,
		OP_SHORT_JMP    = 4'h6,
		OP_WR_HIGH      = 4'h7,
		OP_WR_LOW       = 4'h8,
		OP_RETURN       = 4'h9,
		OP_EXT_IDX      = 4'ha,
		OP_EXT_PTR      = 4'hb,
		OP_PUSH         = 4'hc
	} op_t;

	// ======================================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE         = 3'h0,
		ST_IMM_HIGH     = 3'h1,
		ST_IMM_LOW      = 3'h2,
		ST_JUMP_LOW     = 3'h3,
		ST_MEM_WAIT     = 3'h4,
		ST_POP_HIGH     = 3'h5,
		ST_POP_LOW      = 3'h6,
		ST_POP_LAST     = 3'h7
	} state_t;

	// ======================================================================
	// Memory space of a read
	typedef enum logic {
		SPACE_CODE      = 1'b0,
		SPACE_XDATA     = 1'b1
	} space_t;

endpackage : pointer_unit_pkg

// >>> rtl/pointer_unit_regs.svh
/*
 * Constants of the data pointer and table look-up unit: reset values,
 * field positions and step sizes.
 * Assumes it is included by bare name after the types package.
 */
`ifndef POINTER_UNIT_REGS_SVH
`define POINTER_UNIT_REGS_SVH

// ==========================================================================
// Reset values
`define PTR_RESET       16'h0000
`define PC_RESET        16'h0000
`define SP_RESET        8'h07
`define BYTE_RESET      8'h00
`define PAGE_RESET      3'h0

// ==========================================================================
// Field positions
// Lowest program counter bit kept by the short absolute jump (2K page)
`define PAGE_LSB        11
`define PAGE_MSB        15

// ==========================================================================
// Stack steps
`define SP_STEP         8'h01
`define SP_POP_STEP     8'h02

`endif

// >>> tb/data_pointer_lookup_jump_bench.sv
/*
 * Self-checking bench of the data pointer unit: directed cases, then
 * random commands, each checked against an integer model.
 * Assumes the partner memories in mem_partner and the unit's package.
 */
`timescale 1ns/100ps

module data_pointer_lookup_jump_bench;
	logic         clk, rst, cmd_valid, cmd_ready, byte_valid, mem_req, mem_ack;
	logic         acc_we, pc_we, stack_rd, stack_wr, sp_we, flag_we, flag_seen;
	logic         got_space;
	logic [7:0]   cmd_data, byte_data, acc_in, index_in, sp_in, acc_out;
	logic [7:0]   pointer_high_byte, pointer_low_byte, mem_rdata, stack_addr;
	logic [7:0]   stack_wdata, stack_rdata, sp_out, got_acc, got_sp;
	logic [15:0]  pc_in, mem_addr, pc_out, got_addr, got_pc, got_stk;
	logic [1:0]   delay;
	logic [7:0]   sram [256];
	int           ptr, n_mismatch, compares, i, k;
	int           seed = 47;
	pointer_unit_pkg::op_t     cmd_op;
	pointer_unit_pkg::space_t  mem_space;

	data_pointer_unit i_data_pointer_unit (.clk, .rst, .cmd_valid, .cmd_op,
		.cmd_data, .cmd_ready, .byte_valid, .byte_data, .acc_in, .pc_in,
		.index_in, .sp_in, .pointer_high_byte, .pointer_low_byte, .mem_req,
		.mem_space, .mem_addr, .mem_ack, .mem_rdata, .acc_out, .acc_we,
		.pc_out, .pc_we, .stack_rd, .stack_wr, .stack_addr, .stack_wdata,
		.stack_rdata, .sp_out, .sp_we, .flag_we);
	mem_partner i_mem_partner (.clk, .delay, .mem_req, .mem_space, .mem_addr,
		.mem_ack, .mem_rdata, .stack_rd, .stack_wr, .stack_addr,
		.stack_wdata, .stack_rdata);

	// ======================================================================
	// Clock and pulse monitor
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulses last one cycle, so they are caught at the edge that ends them
	always @(posedge clk) begin
		if (mem_req) {got_addr, got_space} = {mem_addr, mem_space};
		if (acc_we) got_acc = acc_out;
		if (pc_we) got_pc = pc_out;
		if (sp_we) got_sp = sp_out;
		if (stack_wr) got_stk = {stack_addr, stack_wdata};
		if (flag_we) flag_seen = 1'b1;
	end

	// ======================================================================
	// Compare and closing
	task automatic chk(input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		if (n_mismatch == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run

	task automatic mem_chk(input logic [15:0] a, input logic s);
		chk(got_addr, a);
		chk({15'h0, got_space}, {15'h0, s});
		chk({8'h0, got_acc}, {8'h0, a[7:0] ^ a[15:8] ^ (s ? 8'h5a : 8'h00)});
	endtask : mem_chk

	// ======================================================================
	// One command: issue, feed bytes, wait bounded for idle, check model
	task automatic step(input pointer_unit_pkg::op_t op,
		input logic [7:0] d, b1, b2);
		logic [15:0] a;
		int          n;
		{got_addr, got_pc, got_stk, got_acc, got_sp, got_space} = 'x;
		cmd_op = op;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		if (op == pointer_unit_pkg::OP_LOAD_IMM
			|| op == pointer_unit_pkg::OP_SHORT_JMP) begin
			byte_data = b1;
			byte_valid = 1'b1;
			@(posedge clk);
			#1 byte_data = b2;
			byte_valid = (op == pointer_unit_pkg::OP_LOAD_IMM);
			@(posedge clk);
			#1 byte_valid = 1'b0;
		end
		for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (cmd_ready !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		@(posedge clk);
		#1;
		a = ptr[15:0] + {8'h00, acc_in};
		case (op)
			pointer_unit_pkg::OP_LOAD_IMM: ptr = {b1, b2};
			pointer_unit_pkg::OP_INC: ptr = (ptr + 1) % 65536;
			pointer_unit_pkg::OP_WR_HIGH: ptr = {d, ptr[7:0]};
			pointer_unit_pkg::OP_WR_LOW: ptr = {ptr[15:8], d};
			pointer_unit_pkg::OP_CONST_PTR: mem_chk(a, 1'b0);
			pointer_unit_pkg::OP_CONST_PC:
				mem_chk(pc_in + {8'h00, acc_in}, 1'b0);
			pointer_unit_pkg::OP_EXT_IDX:
				mem_chk({8'h00, index_in}, 1'b1);
			pointer_unit_pkg::OP_EXT_PTR: mem_chk(ptr[15:0], 1'b1);
			pointer_unit_pkg::OP_JMP_IDX: chk(got_pc, a);
			pointer_unit_pkg::OP_SHORT_JMP:
				chk(got_pc, {pc_in[15:11], d[2:0], b1});
			pointer_unit_pkg::OP_PUSH: begin
				sram[sp_in + 8'h01] = d;
				chk(got_stk, {sp_in + 8'h01, d});
				chk({8'h0, got_sp}, {8'h0, sp_in + 8'h01});
			end
			pointer_unit_pkg::OP_RETURN: begin
				chk(got_pc, {sram[sp_in], sram[sp_in - 8'h01]});
				chk({8'h0, got_sp}, {8'h0, sp_in - 8'h02});
			end
			default: ;
		endcase
		chk({pointer_high_byte, pointer_low_byte}, ptr[15:0]);
	endtask : step

	// ======================================================================
	// Main sequence: carries and wraps first, then a stack round trip
	initial begin
		{rst, cmd_valid, byte_valid, flag_seen} = 4'h8;
		{cmd_data, byte_data, acc_in, index_in} = 32'h0;
		cmd_op = pointer_unit_pkg::OP_NOP;
		{pc_in, sp_in, delay} = {16'h0000, 8'h07, 2'h0};
		{n_mismatch, compares, ptr} = 0;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
		chk({pointer_high_byte, pointer_low_byte}, 16'h0000);
		step(pointer_unit_pkg::OP_LOAD_IMM, 8'h00, 8'h12, 8'hff);
		step(pointer_unit_pkg::OP_INC, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_WR_HIGH, 8'hff, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_WR_LOW, 8'hff, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_INC, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_WR_HIGH, 8'hff, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_WR_LOW, 8'hf0, 8'h00, 8'h00);
		acc_in = 8'h20;
		step(pointer_unit_pkg::OP_CONST_PTR, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_JMP_IDX, 8'h00, 8'h00, 8'h00);
		{pc_in, index_in, delay} = {16'h7ffe, 8'hc3, 2'h3};
		step(pointer_unit_pkg::OP_CONST_PC, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_SHORT_JMP, 8'h05, 8'h3c, 8'h00);
		step(pointer_unit_pkg::OP_EXT_IDX, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_EXT_PTR, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
		step(pointer_unit_pkg::OP_PUSH, 8'h34, 8'h00, 8'h00);
		sp_in = 8'h08;
		step(pointer_unit_pkg::OP_PUSH, 8'h12, 8'h00, 8'h00);
		sp_in = 8'h09;
		step(pointer_unit_pkg::OP_RETURN, 8'h00, 8'h00, 8'h00);
		// Random commands; the return is left out as its stack is unknown
		for (i = 0; i < 60; i++) begin
			{acc_in, index_in, sp_in} = 24'($random(seed));
			{pc_in, delay} = 18'($random(seed));
			k = 1 + ($unsigned($random(seed)) % 11);
			if (k >= 9) k++;
			step(pointer_unit_pkg::op_t'(k[3:0]), 8'($random(seed)),
				8'($random(seed)), 8'($random(seed)));
		end
		chk({15'h0, flag_seen}, 16'h0000);
		chk({15'h0, flag_seen}, 16'h0000);
		complete_run();
	end
endmodule : data_pointer_lookup_jump_bench

// >>> tb/mem_partner.sv
/*
 * Partner memories of the data pointer unit: program and external data
 * memory with a settable answer delay, and a stack RAM.
 * Assumes the unit's clock and registered, single-cycle request strobes.
 */
`timescale 1ns/100ps

module mem_partner (
	input  wire logic                      clk,
	input  wire logic [1:0]                delay,
	input  wire logic                      mem_req,
	input  wire pointer_unit_pkg::space_t  mem_space,
	input  wire logic [15:0]               mem_addr,
	output logic                           mem_ack,
	output logic [7:0]                     mem_rdata,
	input  wire logic                      stack_rd,
	input  wire logic                      stack_wr,
	input  wire logic [7:0]                stack_addr,
	input  wire logic [7:0]                stack_wdata,
	output logic [7:0]                     stack_rdata
);
	logic [7:0]  ram [256];
	logic        pend;
	logic [1:0]  cnt;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
		stack_rdata = 8'h00;
		pend = 1'b0;
		cnt = 2'h0;
	end

	// ======================================================================
	// Memory answer
	// Data is a pattern of address and space; between answers the lines
	// keep toggling so that a late sample can never pass by luck
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (pend && cnt == 2'h0) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ (mem_space ? 8'h5a : 8'h00);
			pend <= 1'b0;
		end else if (pend) begin
			cnt <= cnt - 2'h1;
		end else if (mem_req) begin
			pend <= 1'b1;
			cnt <= delay;
		end
	end

	// ======================================================================
	// Stack RAM: read data valid the cycle after the strobe, else toggling
	always @(posedge clk) begin
		stack_rdata <= stack_rd ? ram[stack_addr] : ~stack_rdata;
		if (stack_wr) begin
			ram[stack_addr] <= stack_wdata;
		end
	end
endmodule : mem_partner
